// ---- common/acb_pkg.sv ----
// Constants and carrier types of the accumulator, compare and branch unit.
// Assumes a single clock; command words arrive already in this domain.
package acb_pkg;

   // ***********************************************************
   // Instruction numbers and frame layout
   // ***********************************************************
   localparam logic [7:0] INSTR_ARITH = 8'h13;
   localparam logic [7:0] INSTR_COMPARE = 8'h14;
   localparam logic [7:0] INSTR_BRANCH_IF = 8'h15;
   localparam logic [7:0] INSTR_PORT_READ = 8'h0f;
   localparam logic [3:0] FRAME_LAST_IDX = 4'h8;
   localparam logic [7:0] MODULE_ADDR_DEFAULT = 8'h01;

   // ***********************************************************
   // Arithmetic type codes
   // ***********************************************************
   localparam logic [7:0] OP_ADD = 8'h00;
   localparam logic [7:0] OP_SUB = 8'h01;
   localparam logic [7:0] OP_PRODUCT = 8'h02;
   localparam logic [7:0] OP_DIV = 8'h03;
   localparam logic [7:0] OP_REMAINDER = 8'h04;
   localparam logic [7:0] OP_AND = 8'h05;
   localparam logic [7:0] OP_OR = 8'h06;
   localparam logic [7:0] OP_XOR = 8'h07;
   localparam logic [7:0] OP_NOT = 8'h08;
   localparam logic [7:0] OP_LOAD = 8'h09;

   // ***********************************************************
   // Branch condition codes
   // ***********************************************************
   localparam logic [7:0] NULL_RESULT_COND = 8'h00;
   localparam logic [7:0] NONNULL_COND = 8'h01;
   localparam logic [7:0] SAME_COND = 8'h02;
   localparam logic [7:0] DIFFERS_COND = 8'h03;
   localparam logic [7:0] ABOVE_COND = 8'h04;
   localparam logic [7:0] ABOVE_OR_SAME_COND = 8'h05;
   localparam logic [7:0] BELOW_COND = 8'h06;
   localparam logic [7:0] BELOW_OR_SAME_COND = 8'h07;
   localparam logic [7:0] TIMEOUT_FAULT_COND = 8'h08;
   localparam logic [7:0] EXTERNAL_ALARM_COND = 8'h09;
   localparam logic [7:0] DRIFT_FAULT_COND = 8'h0a;
   localparam logic [7:0] POSITION_FAULT_COND = 8'h0b;

   // ***********************************************************
   // Reply status codes and reset values
   // ***********************************************************
   localparam logic [7:0] STATUS_OK = 8'h64;
   localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
   localparam logic [31:0] ACC_RESET = 32'h0000_0000;

   // ***********************************************************
   // Carrier types
   // ***********************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] instr;
      logic [7:0] kind;
      logic [7:0] bank;
      logic [31:0] value;
   } acb_cmd_type;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] instr;
      logic [31:0] value;
   } acb_reply_type;

   typedef struct packed {
      logic same;
      logic above;
      logic below;
   } acb_flags_type;

   typedef struct packed {
      logic timeout;
      logic alarm;
      logic drift;
      logic position;
   } acb_fault_type;

endpackage : acb_pkg

// ---- rtl/acb_unit.sv ----
// Accumulator arithmetic, compare and conditional branch unit.
// Assumes bytes and program words come from logic on i_clk; fault
// lines come from pins and are synchronised here.
//
// Notes on behaviour
// RQ1 - Instruction 19 applies selected operation to accumulator and operand.
// RQ2 - Types 0..4: add, subtract, multiply, divide, remainder.
// RQ3 - Types 5..7: bitwise and, or, exclusive-or with operand.
// RQ4 - Type 8 inverts the accumulator bitwise.
// RQ5 - Type 9 loads the operand into the accumulator.
// RQ6 - Direct mode arithmetic replies status 100 and echoes the operand.
// RQ7 - Arithmetic and compare treat the operand as signed.
// RQ8 - Instruction 20 compares accumulator with operand, sets flags.
// RQ9 - Instruction 21 loads program counter when condition holds.
// RQ10 - Types 0..7: zero, nonzero, equal, unequal, above, above-same, below, below-same.
// RQ11 - Types 8..11 test timeout, alarm, drift and position faults.
// RQ12 - Branch conditions use flags of the latest compare.
// RQ13 - Host uses compare and branch only in stored programs.
// RQ14 - Host uses arithmetic mainly in stored programs.
// RQ15 - Port read loads accumulator standalone, only replies in direct mode.
// RQ16 - Frame: address, instr, type, bank, value MSB first, checksum.
// RQ17 - Compare leaves the accumulator unchanged.
// RQ18 - Accumulator and operand are 32-bit two's complement, wrapping.
`timescale 1ns/1ps
module acb_unit #(
   parameter logic [7:0] MODULE_ADDR = acb_pkg::MODULE_ADDR_DEFAULT
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_standalone,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   input wire logic i_prog_valid,
   input wire acb_pkg::acb_cmd_type i_prog_cmd,
   input wire logic [31:0] i_port_value,
   input wire acb_pkg::acb_fault_type i_faults,
   output logic o_port_req,
   output logic [7:0] o_port_num,
   output logic [7:0] o_port_bank,
   output logic o_reply_valid,
   output acb_pkg::acb_reply_type o_reply,
   output logic o_pc_load,
   output logic [31:0] o_pc_value,
   output logic [31:0] o_acc,
   output acb_pkg::acb_flags_type o_flags
);

   // ***********************************************************
   // Arithmetic
   // ***********************************************************
   function automatic logic [31:0] acb_arith(input logic [7:0] op,
                                             input logic [31:0] acc,
                                             input logic [31:0] opnd);
      logic [63:0] prod;
      prod = 64'($signed(acc) * $signed(opnd));
      acb_arith = acc;
      case (op)
         acb_pkg::OP_ADD: acb_arith = 32'(acc + opnd);
         acb_pkg::OP_SUB: acb_arith = 32'(acc - opnd);
         acb_pkg::OP_PRODUCT: acb_arith = prod[31:0];
         acb_pkg::OP_DIV: begin
            if (opnd != 32'h0000_0000) begin
               acb_arith = 32'($signed(acc) / $signed(opnd));
            end
         end
         acb_pkg::OP_REMAINDER: begin
            if (opnd != 32'h0000_0000) begin
               acb_arith = 32'($signed(acc) % $signed(opnd));
            end
         end
         acb_pkg::OP_AND: acb_arith = acc & opnd;
         acb_pkg::OP_OR: acb_arith = acc | opnd;
         acb_pkg::OP_XOR: acb_arith = acc ^ opnd;
         acb_pkg::OP_NOT: acb_arith = ~acc;
         acb_pkg::OP_LOAD: acb_arith = opnd;
         default: acb_arith = acc;
      endcase
   endfunction : acb_arith

   // ***********************************************************
   // Condition test
   // ***********************************************************
   function automatic logic acb_cond(input logic [7:0] cond,
                                     input acb_pkg::acb_flags_type f,
                                     input acb_pkg::acb_fault_type e);
      case (cond)
         acb_pkg::NULL_RESULT_COND: acb_cond = f.same;
         acb_pkg::NONNULL_COND: acb_cond = !f.same;
         acb_pkg::SAME_COND: acb_cond = f.same;
         acb_pkg::DIFFERS_COND: acb_cond = !f.same;
         acb_pkg::ABOVE_COND: acb_cond = f.above;
         acb_pkg::ABOVE_OR_SAME_COND: acb_cond = f.above | f.same;
         acb_pkg::BELOW_COND: acb_cond = f.below;
         acb_pkg::BELOW_OR_SAME_COND: acb_cond = f.below | f.same;
         acb_pkg::TIMEOUT_FAULT_COND: acb_cond = e.timeout;
         acb_pkg::EXTERNAL_ALARM_COND: acb_cond = e.alarm;
         acb_pkg::DRIFT_FAULT_COND: acb_cond = e.drift;
         acb_pkg::POSITION_FAULT_COND: acb_cond = e.position;
         default: acb_cond = 1'b0;
      endcase
   endfunction : acb_cond

   // ***********************************************************
   // Fault line synchronisers
   // ***********************************************************
   acb_pkg::acb_fault_type fault_meta_q;
   acb_pkg::acb_fault_type fault_q;

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         fault_meta_q <= '0;
         fault_q <= '0;
      end else begin
         fault_meta_q <= i_faults;
         fault_q <= fault_meta_q;
      end
   end

   // ***********************************************************
   // Frame assembly
   // ***********************************************************
   logic [3:0] byte_idx_q;
   logic [63:0] frame_q;
   logic [7:0] sum_q;
   logic frame_done;
   logic frame_good;
   logic frame_bad;

   assign frame_done = i_byte_valid && (byte_idx_q == acb_pkg::FRAME_LAST_IDX);
   // RQ16 checksum and address check
   assign frame_good = frame_done && (sum_q == i_byte)
                       && (frame_q[63:56] == MODULE_ADDR);
   assign frame_bad = frame_done && (sum_q != i_byte)
                      && (frame_q[63:56] == MODULE_ADDR);

   // RQ16 byte order, value MSB first
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         byte_idx_q <= '0;
         frame_q <= '0;
         sum_q <= '0;
      end else if (i_byte_valid) begin
         if (frame_done) begin
            byte_idx_q <= '0;
            sum_q <= '0;
         end else begin
            byte_idx_q <= 4'(byte_idx_q + 4'h1);
            frame_q <= {frame_q[55:0], i_byte};
            sum_q <= 8'(sum_q + i_byte);
         end
      end
   end

   // ***********************************************************
   // Command capture
   // ***********************************************************
   logic cmd_valid_q;
   logic cmd_direct_q;
   acb_pkg::acb_cmd_type cmd_q;

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cmd_valid_q <= 1'b0;
         cmd_direct_q <= 1'b0;
         cmd_q <= '0;
      end else begin
         cmd_valid_q <= 1'b0;
         if (i_standalone && i_prog_valid) begin
            cmd_valid_q <= 1'b1;
            cmd_direct_q <= 1'b0;
            cmd_q <= i_prog_cmd;
         end else if (!i_standalone && frame_good) begin
            cmd_valid_q <= 1'b1;
            cmd_direct_q <= 1'b1;
            cmd_q <= frame_q;
         end
      end
   end

   assign o_port_req = cmd_valid_q
                       && (cmd_q.instr == acb_pkg::INSTR_PORT_READ);
   assign o_port_num = cmd_q.kind;
   assign o_port_bank = cmd_q.bank;

   // ***********************************************************
   // Accumulator
   // ***********************************************************
   logic [31:0] acc_q;

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         acc_q <= acb_pkg::ACC_RESET;
      end else if (cmd_valid_q) begin
         // RQ1 arithmetic into accumulator
         if (cmd_q.instr == acb_pkg::INSTR_ARITH) begin
            // RQ2 RQ3 RQ4 RQ5 RQ18 selected operation
            acc_q <= acb_arith(cmd_q.kind, acc_q, cmd_q.value);
         // RQ15 standalone port read loads
         end else if (cmd_q.instr == acb_pkg::INSTR_PORT_READ
                      && !cmd_direct_q) begin
            acc_q <= i_port_value;
         end
      end
   end

   assign o_acc = acc_q;

   // ***********************************************************
   // Compare flags
   // ***********************************************************
   acb_pkg::acb_flags_type flags_q;

   // RQ8 RQ7 RQ17 signed compare, flags only
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         flags_q <= '0;
      end else if (cmd_valid_q && cmd_q.instr == acb_pkg::INSTR_COMPARE) begin
         flags_q.same <= acc_q == cmd_q.value;
         flags_q.above <= $signed(acc_q) > $signed(cmd_q.value);
         flags_q.below <= $signed(acc_q) < $signed(cmd_q.value);
      end
   end

   assign o_flags = flags_q;

   // ***********************************************************
   // Branch
   // ***********************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_pc_load <= 1'b0;
         o_pc_value <= '0;
      end else begin
         o_pc_load <= 1'b0;
         // RQ9 RQ10 RQ11 RQ12 conditional load
         if (cmd_valid_q && !cmd_direct_q
             && cmd_q.instr == acb_pkg::INSTR_BRANCH_IF
             && acb_cond(cmd_q.kind, flags_q, fault_q)) begin
            o_pc_load <= 1'b1;
            o_pc_value <= cmd_q.value;
         end
      end
   end

   // ***********************************************************
   // Direct mode reply
   // ***********************************************************
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_reply_valid <= 1'b0;
         o_reply <= '0;
      end else begin
         o_reply_valid <= 1'b0;
         if (!i_standalone && frame_bad) begin
            o_reply_valid <= 1'b1;
            o_reply.status <= acb_pkg::STATUS_BAD_CHECKSUM;
            o_reply.instr <= frame_q[55:48];
            o_reply.value <= '0;
         end else if (cmd_valid_q && cmd_direct_q) begin
            case (cmd_q.instr)
               // RQ6 echo operand, status ok
               acb_pkg::INSTR_ARITH,
               acb_pkg::INSTR_COMPARE,
               acb_pkg::INSTR_BRANCH_IF: begin
                  o_reply_valid <= 1'b1;
                  o_reply.status <= acb_pkg::STATUS_OK;
                  o_reply.instr <= cmd_q.instr;
                  o_reply.value <= cmd_q.value;
               end
               // RQ15 direct port read reply only
               acb_pkg::INSTR_PORT_READ: begin
                  o_reply_valid <= 1'b1;
                  o_reply.status <= acb_pkg::STATUS_OK;
                  o_reply.instr <= cmd_q.instr;
                  o_reply.value <= i_port_value;
               end
               default: begin
                  o_reply_valid <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule : acb_unit

// ---- dv/acb_host.sv ----
// Host model that sends command frames to the unit byte by byte.
// Assumes the caller starts just after a rising edge of i_clk.
`timescale 1ns/1ps
module acb_host (
   input wire logic i_clk,
   output logic o_byte_valid,
   output logic [7:0] o_byte
);
   initial begin
      o_byte_valid = 1'b0;
      o_byte = 8'h00;
   end
   task automatic send(acb_pkg::acb_cmd_type c, logic bad, int gap);
      logic [7:0] b [9];
      {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} = c;
      b[8] = {7'h00, bad};
      for (int i = 0; i < 8; i++) b[8] += b[i];
      for (int i = 0; i < 9; i++) begin
         o_byte_valid = 1'b1;
         o_byte = b[i];
         @(posedge i_clk) #1;
         if (gap > 0 || i == 8) begin
            o_byte_valid = 1'b0;
            o_byte = ~b[i];
            repeat (gap) @(posedge i_clk) #1;
         end
      end
   endtask : send
endmodule : acb_host

// ---- dv/acb_unit_asserts.sv ----
// Port checks of the accumulator, compare and branch unit.
// Bound to acb_unit; sees its ports only.
`timescale 1ns/1ps
module acb_unit_asserts (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_standalone,
   input wire logic i_prog_valid,
   input wire acb_pkg::acb_cmd_type i_prog_cmd,
   input wire logic [31:0] i_port_value,
   input wire logic o_port_req,
   input wire logic o_reply_valid,
   input wire logic o_pc_load,
   input wire logic [31:0] o_pc_value,
   input wire logic [31:0] o_acc,
   input wire acb_pkg::acb_flags_type o_flags
);
   logic tk;
   logic [31:0] opv;
   logic [15:0] ik;
   assign tk = i_standalone && i_prog_valid;
   assign opv = i_prog_cmd.value;
   assign ik = {i_prog_cmd.instr, i_prog_cmd.kind};
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // ***********************************************************
   // Program word effects, direct port read and reply pulse
   // ***********************************************************
   load_op_a: assert property (
      tk && ik == 16'h1309 |=> ##1 o_acc == $past(opv, 2))
      else $error("load did not copy operand");
   add_op_a: assert property (
      tk && ik == 16'h1300 |=> ##1 o_acc == $past(o_acc) + $past(opv, 2))
      else $error("add result wrong");
   invert_op_a: assert property (
      tk && ik == 16'h1308 |=> ##1 o_acc == ~$past(o_acc))
      else $error("invert result wrong");
   compare_keeps_acc_a: assert property (
      tk && ik[15:8] == 8'h14 |=> ##1 $stable(o_acc))
      else $error("compare changed accumulator");
   compare_flags_a: assert property (
      tk && ik[15:8] == 8'h14 |=> ##1 o_flags ==
      {$past(o_acc) == $past(opv, 2),
       $signed($past(o_acc)) > $signed($past(opv, 2)),
       $signed($past(o_acc)) < $signed($past(opv, 2))})
      else $error("compare flags wrong");
   branch_cause_a: assert property (
      o_pc_load |-> $past(tk, 2) && $past(ik[15:8], 2) == 8'h15 &&
      o_pc_value == $past(opv, 2))
      else $error("program counter load without branch");
   port_load_a: assert property (
      o_port_req && i_standalone |=> o_acc == $past(i_port_value))
      else $error("port value not in accumulator");
   port_direct_a: assert property (
      o_port_req && !i_standalone |=> $stable(o_acc))
      else $error("direct port read changed accumulator");
   reply_pulse_a: assert property (
      o_reply_valid |=> !o_reply_valid)
      else $error("reply valid held too long");
endmodule : acb_unit_asserts
bind acb_unit acb_unit_asserts acb_unit_asserts_inst (.i_clk, .i_rstn,
   .i_standalone, .i_prog_valid, .i_prog_cmd, .i_port_value, .o_port_req,
   .o_reply_valid, .o_pc_load, .o_pc_value, .o_acc, .o_flags);

// ---- dv/acb_unit_bench.sv ----
// Self-checking bench of the accumulator, compare and branch unit.
// Needs acb_pkg, the host model and the bound checker.
`timescale 1ns/1ps
module acb_unit_bench;
   logic i_clk, i_rstn, i_standalone, i_byte_valid, i_prog_valid;
   logic o_port_req, o_reply_valid, o_pc_load;
   logic [7:0] i_byte, o_port_num, o_port_bank;
   logic [31:0] i_port_value, o_pc_value, o_acc, a, v, e, p;
   acb_pkg::acb_cmd_type i_prog_cmd;
   acb_pkg::acb_fault_type i_faults;
   acb_pkg::acb_reply_type o_reply;
   acb_pkg::acb_flags_type o_flags;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int seed = 32'hc418;
   int np = 0;
   int port_reqs = 0;
   logic [15:0] pq;
   acb_unit acb_unit_inst (.i_clk, .i_rstn, .i_standalone, .i_byte_valid,
      .i_byte, .i_prog_valid, .i_prog_cmd, .i_port_value, .i_faults,
      .o_port_req, .o_port_num, .o_port_bank, .o_reply_valid, .o_reply,
      .o_pc_load, .o_pc_value, .o_acc, .o_flags);
   acb_host acb_host_inst (.i_clk, .o_byte_valid(i_byte_valid),
      .o_byte(i_byte));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // Port request capture, counted per execute cycle
   always @(posedge i_clk) begin
      if (o_port_req === 1'b1) begin
         pq <= {o_port_num, o_port_bank};
         port_reqs++;
      end
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic test_done();
      if (bad_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   task automatic check(string n, logic [47:0] s, logic [47:0] x);
      checks_done++;
      if (s !== x) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask : check
   task automatic prog(logic [7:0] ins, k, logic [31:0] val);
      i_prog_valid = 1'b1;
      i_prog_cmd = {8'h00, ins, k, 8'h00, val};
      @(posedge i_clk) #1;
      i_prog_valid = 1'b0;
      @(posedge i_clk) #1;
   endtask : prog
   task automatic reply(logic want, logic [47:0] x);
      logic seen;
      seen = 1'b0;
      repeat (4) begin
         if (o_reply_valid === 1'b1) begin
            seen = 1'b1;
            check("reply", o_reply, x);
         end
         @(posedge i_clk) #1;
      end
      check("reply_valid", seen, want);
   endtask : reply
   function automatic logic [31:0] arith_want(logic [7:0] op,
      logic [31:0] x, y);
      case (op)
         8'h00: return x + y;
         8'h01: return x - y;
         8'h02: return x * y;
         8'h03: if (y != 0) return $signed(x) / $signed(y);
         8'h04: if (y != 0) return $signed(x) % $signed(y);
         8'h05: return x & y;
         8'h06: return x | y;
         8'h07: return x ^ y;
         8'h08: return ~x;
         8'h09: return y;
      endcase
      return x;
   endfunction : arith_want
   function automatic logic cond(logic [7:0] k, logic [31:0] x, y,
      logic [3:0] f);
      logic eq, gt;
      eq = x == y;
      gt = $signed(x) > $signed(y);
      case (k)
         8'h00, 8'h02: return eq;
         8'h01, 8'h03: return !eq;
         8'h04: return gt;
         8'h05: return gt || eq;
         8'h06: return !(gt || eq);
         8'h07: return !gt;
      endcase
      return f[8'h0b - k];
   endfunction : cond
   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial begin
      i_rstn = 1'b0;
      i_standalone = 1'b1;
      i_prog_valid = 1'b0;
      i_prog_cmd = '0;
      i_port_value = '0;
      i_faults = '0;
      repeat (16) @(posedge i_clk);
      #1 i_rstn = 1'b1;
      check("acc", o_acc, 48'h0);
      check("flags", o_flags, 48'h0);
      // load, arithmetic, compare, branch and port read as program words
      repeat (20) begin
         a = $random(seed);
         prog(8'h13, 8'h09, a);
         check("acc", o_acc, a);
         for (int k = 0; k < 10; k++) begin
            v = $random(seed);
            if (k % 3 == 0) v = (k == 3) ? 32'h0 : 32'hffffec78;
            e = arith_want(k[7:0], a, v);
            prog(8'h13, k[7:0], v);
            check("acc", o_acc, e);
            a = e;
         end
         i_faults = 4'($random(seed));
         v = $random(seed);
         p = $random(seed);
         case (p[1:0])
            2'h0: v = a;
            2'h1: v = a + 32'h1;
            2'h2: v = a - 32'h1;
         endcase
         prog(8'h14, p[15:8], v);
         check("acc", o_acc, a);
         e = {a == v, $signed(a) > $signed(v), $signed(a) < $signed(v)};
         check("flags", o_flags, e);
         for (int k = 0; k < 12; k++) begin
            p = $random(seed);
            prog(8'h15, k[7:0], p);
            e = cond(k[7:0], a, v, i_faults);
            check("pc_load", o_pc_load, e);
            if (e[0]) check("pc", o_pc_value, p);
         end
         i_port_value = $random(seed);
         p = $random(seed);
         prog(8'h0f, p[7:0], 32'h0);
         a = i_port_value;
         check("acc", o_acc, a);
         np++;
         check("port", pq, {p[7:0], 8'h00});
         check("port_reqs", port_reqs, np);
      end
      i_standalone = 1'b0;
      for (int k = 0; k < 10; k++) begin
         v = $random(seed);
         acb_host_inst.send({8'h01, 8'h13, k[7:0], 8'h00, v}, 1'b0, k % 2);
         reply(1'b1, {acb_pkg::STATUS_OK, 8'h13, v});
         a = arith_want(k[7:0], a, v);
         check("acc", o_acc, a);
      end
      i_port_value = $random(seed);
      acb_host_inst.send({8'h01, 8'h0f, 8'h02, 8'h01, 32'h0}, 1'b0, 0);
      reply(1'b1, {acb_pkg::STATUS_OK, 8'h0f, i_port_value});
      check("acc", o_acc, a);
      np++;
      check("port", pq, {8'h02, 8'h01});
      check("port_reqs", port_reqs, np);
      acb_host_inst.send({8'h01, 8'h13, 8'h09, 8'h00, 32'h7}, 1'b1, 0);
      reply(1'b1, {acb_pkg::STATUS_BAD_CHECKSUM, 8'h13, 32'h0});
      acb_host_inst.send({8'h02, 8'h13, 8'h09, 8'h00, 32'h7}, 1'b0, 0);
      reply(1'b0, 48'h0);
      i_standalone = 1'b1;
      acb_host_inst.send({8'h01, 8'h13, 8'h09, 8'h00, 32'h7}, 1'b0, 0);
      reply(1'b0, 48'h0);
      check("acc", o_acc, a);
      test_done();
   end
endmodule : acb_unit_bench
